/* core/fskm_pkg.sv */
// Constants and types for the FSK modem mode and retiming core
package fskm_pkg;
    // System clock and bit rate
    localparam int unsigned CLK_HZ      = 25_000_000;
    localparam int unsigned BIT_HZ      = 1200;
    localparam int unsigned BIT_CYC     = CLK_HZ / BIT_HZ;
    // Energy detect time hysteresis, microseconds
    localparam int unsigned EDET_ON_US  = 10_000;
    localparam int unsigned EDET_OFF_US = 10_000;
    localparam int unsigned CYC_PER_US  = CLK_HZ / 1_000_000;
    localparam int unsigned EDET_ON_CYC  = EDET_ON_US * CYC_PER_US;
    localparam int unsigned EDET_OFF_CYC = EDET_OFF_US * CYC_PER_US;
    localparam int unsigned CNT_W       = 20;
    // Character framing
    localparam int unsigned RX_BITS     = 9;
    localparam logic [3:0]  RX_LAST_BIT = 4'h8;
    localparam logic [3:0]  STB_LAST    = 4'h8;
    // Mode pin decode {b1,b0}
    localparam logic [1:0] MODE_RX_TX75  = 2'h0;
    localparam logic [1:0] MODE_TX_1200  = 2'h1;
    localparam logic [1:0] MODE_RX_ONLY  = 2'h2;
    localparam logic [1:0] MODE_SLEEP    = 2'h3;
    // Synchronised pin vector positions
    localparam int unsigned PIN_W     = 6;
    localparam int unsigned PIN_M0    = 0;
    localparam int unsigned PIN_M1    = 1;
    localparam int unsigned PIN_STB   = 2;
    localparam int unsigned PIN_TXD   = 3;
    localparam int unsigned PIN_DEMOD = 4;
    localparam int unsigned PIN_LVL   = 5;
    localparam logic [5:0]  PIN_RST   = 6'h07;
    // Register port
    localparam int unsigned ADDR_W     = 4;
    localparam logic [3:0]  REG_CTRL   = 4'h0;
    localparam logic [3:0]  REG_STATUS = 4'h4;
    localparam int unsigned CTRL_EQ    = 0;
    localparam int unsigned CTRL_RTM   = 1;
    localparam logic [1:0]  CTRL_RST   = 2'h2;
    localparam int unsigned ST_MODE    = 0;
    localparam int unsigned ST_SLEEP   = 2;
    localparam int unsigned ST_FLAG    = 3;
    localparam int unsigned ST_RDY     = 4;
    localparam int unsigned ST_RXPRES  = 5;
    localparam int unsigned ST_TXHOLD  = 6;
    // Tone selection for the modulator
    typedef enum logic [2:0] {
        TONE_MID  = 3'h0,
        TONE_450  = 3'h1,
        TONE_390  = 3'h2,
        TONE_2100 = 3'h3,
        TONE_1300 = 3'h4
    } fskm_tone_t;
    // Receive character search, Gray except the step from data back to hunt
    typedef enum logic [1:0] {
        RX_HUNT  = 2'h0,
        RX_START = 2'h1,
        RX_DATA  = 2'h3
    } fskm_rx_st_t;
endpackage : fskm_pkg

/* core/fskm_core.sv */
// Mode decode, energy flag, tone select and data retiming of the FSK modem
`timescale 1ns/100ps
// What this block does
// - Mode pins select receive and transmit; retiming also needs CTRL_RTM set; 11 is sleep.
// - Sleep stops the oscillator enable and idles all paths but the register port.
// - Energy flag rises only after level stays high long enough; hysteresis.
// - Without receive retiming, receive output carries raw demodulator data.
// - Receiver off or sleeping forces energy flag and receive data low.
// - Tone chosen from transmit bit and mode; mode 10 is mid-rail.
// - Retimed character: start bit, then first nine bits captured.
// - First register stores nine bits after a falling demodulator edge.
// - On ninth bit copy to second register, restart search, sample strobe.
// - Strobe low then: assert ready, present first captured bit.
// - Nine strobe pulses; eight falls shift bits; ninth reconnects demodulator.
// - Receive ready released at first strobe high after assertion.
// - Strobe held high: pass data straight, never assert ready.
// - Transmit retimer: two one-bit registers, second on 1200 Hz tick.
// - At tick: strobe high passes input; low holds register, asserts ready.
// - Strobe high releases ready; strobe rise latches input into first register.
// - The 75 bit/s transmit path always follows the input directly.
module fskm_core #(
    parameter int unsigned BIT_CYC      = fskm_pkg::BIT_CYC,
    parameter int unsigned EDET_ON_CYC  = fskm_pkg::EDET_ON_CYC,
    parameter int unsigned EDET_OFF_CYC = fskm_pkg::EDET_OFF_CYC
) (
    // Clock and reset
    input  wire logic                        i_clk_sys,
    input  wire logic                        i_arst_n,
    // Host pins
    input  wire logic                        i_mode_select_b0,
    input  wire logic                        i_mode_select_b1,
    input  wire logic                        i_strobe,
    input  wire logic                        i_tx_data,
    // Analog front end
    input  wire logic                        i_demod_data,
    input  wire logic                        i_level_above,
    // Outputs to host
    output logic                             o_rx_data,
    output logic                             o_carrier_energy_flag,
    output logic                             o_transfer_ready_n_o,
    output logic                             o_transfer_ready_n_oe,
    // Modulator, power and equaliser control
    output fskm_pkg::fskm_tone_t             o_tone_output,
    output logic                             o_sleep_state,
    output logic                             o_osc_enable,
    output logic                             o_rx_equaliser_select,
    // Register port
    input  wire logic [fskm_pkg::ADDR_W-1:0] i_reg_addr,
    input  wire logic [31:0]                 i_reg_wdata,
    input  wire logic                        i_reg_wr,
    input  wire logic                        i_reg_rd,
    output logic [31:0]                      o_reg_rdata
);

    if (BIT_CYC < 4 || BIT_CYC >= (1 << fskm_pkg::CNT_W)) begin : g_bad_bit
        $error("BIT_CYC out of range");
    end
    if (EDET_ON_CYC < 1 || EDET_ON_CYC >= (1 << fskm_pkg::CNT_W) ||
        EDET_OFF_CYC < 1 || EDET_OFF_CYC >= (1 << fskm_pkg::CNT_W)) begin : g_bad_edet
        $error("Energy detect counts out of range");
    end

    localparam logic [fskm_pkg::CNT_W-1:0] BIT_LD  = fskm_pkg::CNT_W'(BIT_CYC - 1);
    localparam logic [fskm_pkg::CNT_W-1:0] HALF_LD = fskm_pkg::CNT_W'(BIT_CYC / 2 - 1);
    localparam logic [fskm_pkg::CNT_W-1:0] ON_LD   = fskm_pkg::CNT_W'(EDET_ON_CYC - 1);
    localparam logic [fskm_pkg::CNT_W-1:0] OFF_LD  = fskm_pkg::CNT_W'(EDET_OFF_CYC - 1);

    function automatic logic cnt_zero(input logic [fskm_pkg::CNT_W-1:0] c);
        return c == '0;
    endfunction : cnt_zero

    // Pin synchronisers; a change counts when stages two and three agree
    logic [fskm_pkg::PIN_W-1:0] pin_s1_ff;
    logic [fskm_pkg::PIN_W-1:0] pin_s2_ff;
    logic [fskm_pkg::PIN_W-1:0] pin_s3_ff;
    logic [fskm_pkg::PIN_W-1:0] pin_ff;
    logic                       stb_prev_ff;
    logic                       demod_prev_ff;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_s1_ff     <= fskm_pkg::PIN_RST;
            pin_s2_ff     <= fskm_pkg::PIN_RST;
            pin_s3_ff     <= fskm_pkg::PIN_RST;
            pin_ff        <= fskm_pkg::PIN_RST;
            stb_prev_ff   <= 1'b1;
            demod_prev_ff <= 1'b0;
        end else begin
            pin_s1_ff     <= {i_level_above, i_demod_data, i_tx_data, i_strobe,
                              i_mode_select_b1, i_mode_select_b0};
            pin_s2_ff     <= pin_s1_ff;
            pin_s3_ff     <= pin_s2_ff;
            pin_ff        <= (pin_s2_ff & pin_s3_ff) | (pin_ff & (pin_s2_ff ^ pin_s3_ff));
            stb_prev_ff   <= pin_ff[fskm_pkg::PIN_STB];
            demod_prev_ff <= pin_ff[fskm_pkg::PIN_DEMOD];
        end
    end

    logic [1:0] mode;
    logic       stb;
    logic       txd;
    logic       demod;
    logic       stb_rise;
    logic       stb_fall;
    logic       sleep;
    logic       rx_on;
    logic       rx_retime;
    logic       tx_retime;
    logic [1:0] ctrl_ff;

    assign mode      = {pin_ff[fskm_pkg::PIN_M1], pin_ff[fskm_pkg::PIN_M0]};
    assign stb       = pin_ff[fskm_pkg::PIN_STB];
    assign txd       = pin_ff[fskm_pkg::PIN_TXD];
    assign demod     = pin_ff[fskm_pkg::PIN_DEMOD];
    assign stb_rise  = stb & ~stb_prev_ff;
    assign stb_fall  = ~stb & stb_prev_ff;
    assign sleep     = mode == fskm_pkg::MODE_SLEEP;
    assign rx_on     = mode == fskm_pkg::MODE_RX_TX75 || mode == fskm_pkg::MODE_RX_ONLY;
    assign rx_retime = rx_on & ctrl_ff[fskm_pkg::CTRL_RTM];
    assign tx_retime = (mode == fskm_pkg::MODE_TX_1200) & ctrl_ff[fskm_pkg::CTRL_RTM];

    // Energy flag with time hysteresis; amplitude hysteresis is in the comparator
    logic                       edet_ff;
    logic [fskm_pkg::CNT_W-1:0] edet_cnt_ff;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            edet_ff     <= 1'b0;
            edet_cnt_ff <= '0;
        end else if (!rx_on) begin
            edet_ff     <= 1'b0;
            edet_cnt_ff <= ON_LD;
        end else if (pin_ff[fskm_pkg::PIN_LVL] == edet_ff) begin
            edet_cnt_ff <= edet_ff ? OFF_LD : ON_LD;
        end else if (cnt_zero(edet_cnt_ff)) begin
            edet_ff     <= ~edet_ff;
            edet_cnt_ff <= edet_ff ? ON_LD : OFF_LD;
        end else begin
            edet_cnt_ff <= edet_cnt_ff - 1'b1;
        end
    end

    // Receive character search and first register
    fskm_pkg::fskm_rx_st_t       rx_st_ff;
    logic [fskm_pkg::CNT_W-1:0]  rx_cnt_ff;
    logic [3:0]                  rx_bitn_ff;
    logic [fskm_pkg::RX_BITS-1:0] rx_sh1_ff;
    logic                        rx_done;

    assign rx_done = rx_st_ff == fskm_pkg::RX_DATA && cnt_zero(rx_cnt_ff) &&
                     rx_bitn_ff == fskm_pkg::RX_LAST_BIT;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rx_st_ff   <= fskm_pkg::RX_HUNT;
            rx_cnt_ff  <= '0;
            rx_bitn_ff <= 4'h0;
            rx_sh1_ff  <= '0;
        end else if (!rx_retime) begin
            rx_st_ff   <= fskm_pkg::RX_HUNT;
            rx_cnt_ff  <= '0;
            rx_bitn_ff <= 4'h0;
        end else begin
            case (rx_st_ff)
                fskm_pkg::RX_HUNT: begin
                    if (demod_prev_ff && !demod) begin
                        rx_st_ff  <= fskm_pkg::RX_START;
                        rx_cnt_ff <= HALF_LD;
                    end
                end
                fskm_pkg::RX_START: begin
                    if (!cnt_zero(rx_cnt_ff)) begin
                        rx_cnt_ff <= rx_cnt_ff - 1'b1;
                    end else if (demod) begin
                        rx_st_ff <= fskm_pkg::RX_HUNT;
                    end else begin
                        rx_st_ff   <= fskm_pkg::RX_DATA;
                        rx_cnt_ff  <= BIT_LD;
                        rx_bitn_ff <= 4'h0;
                    end
                end
                fskm_pkg::RX_DATA: begin
                    if (!cnt_zero(rx_cnt_ff)) begin
                        rx_cnt_ff <= rx_cnt_ff - 1'b1;
                    end else begin
                        rx_sh1_ff  <= {demod, rx_sh1_ff[fskm_pkg::RX_BITS-1:1]};
                        rx_bitn_ff <= rx_bitn_ff + 4'h1;
                        rx_cnt_ff  <= BIT_LD;
                        if (rx_done) begin
                            rx_st_ff <= fskm_pkg::RX_HUNT;
                        end
                    end
                end
                default: rx_st_ff <= fskm_pkg::RX_HUNT;
            endcase
        end
    end

    // Second register and strobe driven presentation
    logic [fskm_pkg::RX_BITS-1:0] rx_sh2_ff;
    logic                         rx_pres_ff;
    logic                         rx_rdy_ff;
    logic [3:0]                   rx_pulse_ff;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rx_sh2_ff   <= '0;
            rx_pres_ff  <= 1'b0;
            rx_rdy_ff   <= 1'b0;
            rx_pulse_ff <= 4'h0;
        end else if (!rx_retime) begin
            rx_pres_ff  <= 1'b0;
            rx_rdy_ff   <= 1'b0;
            rx_pulse_ff <= 4'h0;
        end else if (rx_done) begin
            // Character copied; a new one overrides a late transfer
            rx_sh2_ff <= {demod, rx_sh1_ff[fskm_pkg::RX_BITS-1:1]};
            if (!stb) begin
                rx_pres_ff  <= 1'b1;
                rx_rdy_ff   <= 1'b1;
                rx_pulse_ff <= 4'h0;
            end
        end else if (rx_pres_ff) begin
            if (stb_rise) begin
                rx_rdy_ff <= 1'b0;
            end
            if (stb_fall) begin
                rx_pulse_ff <= rx_pulse_ff + 4'h1;
                if (rx_pulse_ff == fskm_pkg::STB_LAST) begin
                    rx_pres_ff <= 1'b0;
                end else begin
                    rx_sh2_ff <= rx_sh2_ff >> 1;
                end
            end
        end
    end

    // Transmit retimer, two one-bit stages and a 1200 Hz tick
    logic [fskm_pkg::CNT_W-1:0] tx_cnt_ff;
    logic                       tx_tick;
    logic                       tx_r1_ff;
    logic                       tx_r2_ff;
    logic                       tx_hold_ff;
    logic                       tx_rdy_ff;

    assign tx_tick = tx_retime && cnt_zero(tx_cnt_ff);

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tx_cnt_ff <= '0;
        end else if (!tx_retime || cnt_zero(tx_cnt_ff)) begin
            tx_cnt_ff <= BIT_LD;
        end else begin
            tx_cnt_ff <= tx_cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tx_r1_ff   <= 1'b1;
            tx_r2_ff   <= 1'b1;
            tx_hold_ff <= 1'b0;
            tx_rdy_ff  <= 1'b0;
        end else if (!tx_retime) begin
            tx_hold_ff <= 1'b0;
            tx_rdy_ff  <= 1'b0;
        end else begin
            if (stb_rise) begin
                tx_r1_ff <= txd;
            end
            if (tx_tick) begin
                tx_r2_ff   <= tx_r1_ff;
                tx_hold_ff <= ~stb;
            end
            if (tx_tick && !stb) begin
                tx_rdy_ff <= 1'b1;
            end else if (stb) begin
                tx_rdy_ff <= 1'b0;
            end
        end
    end

    // Registered pin outputs
    logic tx_bit;
    assign tx_bit = tx_hold_ff ? tx_r2_ff : txd;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_tone_output <= fskm_pkg::TONE_MID;
        end else begin
            case (mode)
                fskm_pkg::MODE_RX_TX75:
                    o_tone_output <= txd ? fskm_pkg::TONE_390 : fskm_pkg::TONE_450;
                fskm_pkg::MODE_TX_1200:
                    o_tone_output <= tx_bit ? fskm_pkg::TONE_1300 : fskm_pkg::TONE_2100;
                default: o_tone_output <= fskm_pkg::TONE_MID;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rx_data             <= 1'b0;
            o_carrier_energy_flag <= 1'b0;
            o_transfer_ready_n_oe <= 1'b0;
            o_sleep_state         <= 1'b1;
            o_osc_enable          <= 1'b0;
        end else begin
            o_rx_data             <= rx_on & (rx_pres_ff ? rx_sh2_ff[0] : demod);
            o_carrier_energy_flag <= rx_on & edet_ff;
            o_transfer_ready_n_oe <= rx_rdy_ff | tx_rdy_ff;
            o_sleep_state         <= sleep;
            o_osc_enable          <= ~sleep;
        end
    end

    // Open drain: only ever pulls low
    assign o_transfer_ready_n_o  = 1'b0;
    assign o_rx_equaliser_select = ctrl_ff[fskm_pkg::CTRL_EQ];

    // Register port
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_ff <= fskm_pkg::CTRL_RST;
        end else if (i_reg_wr && i_reg_addr == fskm_pkg::REG_CTRL) begin
            ctrl_ff <= i_reg_wdata[1:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_reg_rdata <= 32'h0;
        end else begin
            o_reg_rdata <= 32'h0;
            if (i_reg_rd && i_reg_addr == fskm_pkg::REG_CTRL) begin
                o_reg_rdata[1:0] <= ctrl_ff;
            end else if (i_reg_rd && i_reg_addr == fskm_pkg::REG_STATUS) begin
                o_reg_rdata[fskm_pkg::ST_MODE +: 2] <= mode;
                o_reg_rdata[fskm_pkg::ST_SLEEP]     <= sleep;
                o_reg_rdata[fskm_pkg::ST_FLAG]      <= edet_ff;
                o_reg_rdata[fskm_pkg::ST_RDY]       <= rx_rdy_ff | tx_rdy_ff;
                o_reg_rdata[fskm_pkg::ST_RXPRES]    <= rx_pres_ff;
                o_reg_rdata[fskm_pkg::ST_TXHOLD]    <= tx_hold_ff;
            end
        end
    end

    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);

    sequence s_tick_low;
        tx_tick && !stb;
    endsequence
    sequence s_rx_fall;
        rx_retime && rx_pres_ff && stb_fall && !rx_done;
    endsequence

    a_sleep_quiet: assert property (sleep |=>
        !o_rx_data && !o_carrier_energy_flag && !o_osc_enable && o_sleep_state)
        else $error("Outputs active in sleep");
    a_rxoff_low: assert property (mode == fskm_pkg::MODE_TX_1200 |=>
        !o_rx_data && !o_carrier_energy_flag)
        else $error("Receive outputs high with receiver off");
    a_raw_pass: assert property (rx_on && !rx_pres_ff |=> o_rx_data == $past(demod))
        else $error("Receive output not raw demodulator");
    a_rx_present: assert property (rx_retime && rx_done && !stb |=>
        rx_rdy_ff && rx_pres_ff ##1 o_rx_data == rx_sh2_ff[0] && o_transfer_ready_n_oe)
        else $error("Ready or first bit missing");
    a_stb_high_pass: assert property (rx_done && stb && !rx_pres_ff |=> !rx_pres_ff)
        else $error("Presentation started with strobe high");
    a_rx_release: assert property (rx_pres_ff && stb_rise && !rx_done |=> !rx_rdy_ff)
        else $error("Ready not released on strobe high");
    a_rx_shift: assert property (s_rx_fall and rx_pulse_ff < fskm_pkg::STB_LAST
        |=> rx_sh2_ff == ($past(rx_sh2_ff) >> 1) && rx_pres_ff)
        else $error("Retimed bit not shifted");
    a_rx_reconnect: assert property (s_rx_fall and rx_pulse_ff == fskm_pkg::STB_LAST
        |=> !rx_pres_ff)
        else $error("Demodulator not reconnected");
    a_tx_hold: assert property (s_tick_low |=> tx_rdy_ff && tx_hold_ff
        && tx_r2_ff == $past(tx_r1_ff))
        else $error("Transmit tick did not hold");
    a_tx_release: assert property (tx_rdy_ff && stb |=> !tx_rdy_ff)
        else $error("Transmit ready not released");
    a_tx75_direct: assert property (mode == fskm_pkg::MODE_RX_TX75 |=>
        o_tone_output == ($past(txd) ? fskm_pkg::TONE_390 : fskm_pkg::TONE_450))
        else $error("Back channel tone not direct");
    a_edet_cause: assert property (!edet_ff && !pin_ff[fskm_pkg::PIN_LVL] |=> !edet_ff)
        else $error("Energy flag rose without level");

endmodule : fskm_core

/* tb/fskm_host.sv */
// Host model that reads retimed receive characters with strobe pulses
`timescale 1ns/100ps
module fskm_host (
    // Clock and enable
    input  wire logic i_clk_sys,
    input  wire logic i_en,
    // Device pins, character and done flag
    input  wire logic i_ready_n,
    input  wire logic i_rx_data,
    output logic      o_strobe,
    output logic [8:0] o_char,
    output logic      o_done
);
    initial begin
        o_strobe = 1'h1;
        o_char = 9'h000;
        o_done = 1'h0;
        forever begin
            @(posedge i_clk_sys);
            o_strobe <= !i_en || o_done; // Low only while waiting
            if (!i_en) begin
                o_done <= 1'h0;
            end
            if (i_en && !o_done && !i_ready_n) begin
                for (int i = 0; i < 9; i++) begin
                    // Shifted bit needs sync plus two registers after a fall
                    repeat (8) @(posedge i_clk_sys);
                    o_char[i] <= i_rx_data;
                    o_strobe <= 1'h1;
                    repeat (6) @(posedge i_clk_sys);
                    o_strobe <= 1'h0;
                end
                // Last fall must outlast the synchroniser
                repeat (8) @(posedge i_clk_sys);
                o_done <= 1'h1; // 134 cycles, inside one character
            end
        end
    end
endmodule : fskm_host

/* tb/fskm_core_bench.sv */
// Self-checking bench for the FSK modem mode and retiming core
`timescale 1ns/100ps
module fskm_core_bench;
    logic clk, rst_n, b0, b1, tb_stb, txd, demod, lvl, wr, rd, host_en, h_stb, h_done;
    logic rx_data, flag, rdy_o, rdy_oe, sleep, osc, eq;
    logic [3:0] addr;
    logic [31:0] wdata, rdata;
    logic [8:0] h_char;
    fskm_pkg::fskm_tone_t tone;
    int err_count, cmp_count;
    wire rdy_pin_n = rdy_oe ? rdy_o : 1'h1;
    fskm_core #(.BIT_CYC(16), .EDET_ON_CYC(8), .EDET_OFF_CYC(8)) u_dut (
        .i_clk_sys(clk), .i_arst_n(rst_n), .i_mode_select_b0(b0), .i_mode_select_b1(b1),
        .i_strobe(host_en ? h_stb : tb_stb), .i_tx_data(txd), .i_demod_data(demod),
        .i_level_above(lvl), .o_rx_data(rx_data), .o_carrier_energy_flag(flag),
        .o_transfer_ready_n_o(rdy_o), .o_transfer_ready_n_oe(rdy_oe), .o_tone_output(tone),
        .o_sleep_state(sleep), .o_osc_enable(osc), .o_rx_equaliser_select(eq),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata));
    fskm_host u_host (.i_clk_sys(clk), .i_en(host_en), .i_ready_n(rdy_pin_n),
        .i_rx_data(rx_data), .o_strobe(h_stb), .o_char(h_char), .o_done(h_done));
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic set_mode(input logic [1:0] m);
        @(posedge clk);
        {b1, b0} <= m;
        repeat (8) @(posedge clk);
    endtask : set_mode
    task automatic reg_acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        {wr, rd} <= {w, !w};
        addr <= a;
        wdata <= d;
        @(posedge clk);
        {wr, rd} <= 2'h0;
        cyc(0);
        if (!w) chk("rdata", d, rdata);
    endtask : reg_acc
    task automatic wait_rdy();
        for (int k = 0; k < 40 && rdy_oe !== 1'h1; k++) begin
            cyc(1);
        end
        chk("ready", 1'h1, rdy_oe);
    endtask : wait_rdy
    task automatic t_sleep_regs();
        chk("sleep", 1'h1, sleep);
        chk("osc", 1'h0, osc);
        chk("flag", 1'h0, flag);
        chk("rxd", 1'h0, rx_data);
        reg_acc(1'h0, fskm_pkg::REG_STATUS, 32'h0000_0007);
        reg_acc(1'h0, fskm_pkg::REG_CTRL, 32'h0000_0002);
        reg_acc(1'h1, fskm_pkg::REG_CTRL, 32'h0000_0003);
        chk("equaliser", 1'h1, eq);
        reg_acc(1'h0, 4'h8, 32'h0000_0000);
        reg_acc(1'h1, fskm_pkg::REG_CTRL, 32'h0000_0002);
        chk("equaliser", 1'h0, eq);
        $display("test sleep_regs done");
    endtask : t_sleep_regs
    task automatic t_tone();
        fskm_pkg::fskm_tone_t tbl [6];
        tbl = '{fskm_pkg::TONE_450, fskm_pkg::TONE_390, fskm_pkg::TONE_2100,
                fskm_pkg::TONE_1300, fskm_pkg::TONE_MID, fskm_pkg::TONE_MID};
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            txd <= i[0];
            set_mode(2'(i / 2));
            cyc(16);
            chk("tone", tbl[i], tone);
        end
        $display("test tone done");
    endtask : t_tone
    task automatic t_energy();
        set_mode(2'h0);
        lvl <= 1'h1;
        repeat (6) @(posedge clk);
        lvl <= 1'h0;
        cyc(12);
        chk("flag", 1'h0, flag); // Short burst ignored
        @(posedge clk);
        lvl <= 1'h1;
        cyc(20);
        chk("flag", 1'h1, flag);
        set_mode(2'h1);
        cyc(4);
        chk("flag", 1'h0, flag);
        chk("rxd", 1'h0, rx_data);
        @(posedge clk);
        lvl <= 1'h0;
        $display("test energy done");
    endtask : t_energy
    task automatic t_pass();
        logic seen;
        set_mode(2'h2);
        demod <= 1'h0;
        cyc(12);
        chk("rxd", 1'h0, rx_data);
        @(posedge clk);
        demod <= 1'h1;
        seen = 1'h0;
        for (int k = 0; k < 200; k++) begin
            cyc(1);
            seen = seen | rdy_oe;
        end
        chk("rxd", 1'h1, rx_data);
        chk("ready", 1'h0, seen); // Strobe high keeps ready idle
        $display("test passthrough done");
    endtask : t_pass
    task automatic t_rx();
        set_mode(2'h0);
        host_en <= 1'h1;
        repeat (8) @(posedge clk);
        demod <= 1'h0;
        repeat (16) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            demod <= i[0] ? 1'h0 : 1'h1;
            repeat (16) @(posedge clk);
        end
        demod <= 1'h1;
        for (int k = 0; k < 300 && h_done !== 1'h1; k++) begin
            cyc(1);
        end
        chk("char", 9'h155, h_char);
        chk("ready", 1'h0, rdy_oe);
        @(posedge clk);
        host_en <= 1'h0;
        demod <= 1'h0;
        cyc(12);
        chk("rxd", 1'h0, rx_data); // Raw data restored
        @(posedge clk);
        demod <= 1'h1;
        $display("test rx_retime done");
    endtask : t_rx
    task automatic t_tx();
        set_mode(2'h1);
        tb_stb <= 1'h0;
        txd <= 1'h0; // First bit steady from entry
        wait_rdy();
        for (int b = 0; b < 2; b++) begin
            @(posedge clk);
            txd <= b[0]; // Next bit once ready
            @(posedge clk);
            tb_stb <= 1'h1;
            cyc(8);
            chk("ready", 1'h0, rdy_oe);
            @(posedge clk);
            tb_stb <= 1'h0;
            wait_rdy();
            chk("tone", b[0] ? fskm_pkg::TONE_1300 : fskm_pkg::TONE_2100, tone);
            @(posedge clk);
            txd <= !b[0];
            cyc(8);
            chk("held", b[0] ? fskm_pkg::TONE_1300 : fskm_pkg::TONE_2100, tone);
        end
        set_mode(2'h3);
        cyc(0);
        chk("ready", 1'h0, rdy_oe);
        chk("tone", fskm_pkg::TONE_MID, tone);
        @(posedge clk);
        tb_stb <= 1'h1;
        txd <= 1'h1; // Last bit level kept after exit
        set_mode(2'h1);
        cyc(20); // Settle after sleep, scaled down
        chk("ready", 1'h0, rdy_oe);
        chk("tone", fskm_pkg::TONE_1300, tone);
        $display("test tx_retime done");
    endtask : t_tx
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        {rst_n, wr, rd, host_en, lvl, txd} = 6'h00;
        {b1, b0, tb_stb, demod} = 4'hF; // Sleep until supply and clock run
        addr = 4'h0;
        wdata = 32'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        cyc(8);
        t_sleep_regs();
        t_tone();
        t_energy();
        t_pass();
        t_rx();
        t_tx();
        wrap_up();
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        wrap_up();
    end
endmodule : fskm_core_bench
